//--- hdl/rns_store.sv
// Ten-number repertory store on a shared four-line keyboard bus
`timescale 1ns/1ns
`default_nettype none
`include "rns_consts.svh"
module rns_store #(
    parameter int NUMBERS = `RNS_NUMBERS,
    parameter int CHARS = `RNS_CHARS,
    parameter int RETRIEVE_CYC = `RNS_RETRIEVE_CYC,
    parameter int STROBE_CYC = `RNS_STROBE_CYC,
    parameter int DEBOUNCE_CYC = `RNS_DEBOUNCE_CYC,
    parameter logic [3:0] CODE_PAUSE = `RNS_CODE_PAUSE,
    parameter logic [3:0] CODE_ZERO = `RNS_CODE_ZERO
) (
    // Clock and resets
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic por_n_in,
    // Control pins
    input wire logic chip_select_in,
    input wire logic retrieve_in,
    input wire logic ctrl_enable_in,
    input wire logic store_in,
    input wire logic common_key_n_in,
    // Four-line data bus, split into in, out and enable
    input wire logic bus_line_one_in,
    input wire logic bus_line_two_in,
    input wire logic bus_line_three_in,
    input wire logic bus_line_four_in,
    output logic bus_line_one_out,
    output logic bus_line_two_out,
    output logic bus_line_three_out,
    output logic bus_line_four_out,
    output logic [3:0] bus_oe_out,
    // Keyboard disables and dialler strobe
    output logic dig_kbd_dis_n_out,
    output logic addr_kbd_dis_n_out,
    output logic common_key_n_out
);
    // Counter width covers the longest strobe interval
    localparam int CW = 24;
    localparam int AW = $clog2(CHARS + 1);

    // Whole module state in one packed struct
    typedef struct packed {
        logic [1:0][4:0] sync;
        logic [4:0] filt;
        logic [4:0] filt_d;
        logic [4:0][CW-1:0] cnt;
        rns_pkg::rns_state_type fsm;
        logic is_store;
        logic [3:0] addr;
        logic [AW-1:0] idx;
        logic [AW-1:0] len;
        logic [CW-1:0] timer;
        logic [CW-1:0] ret_high;
        logic ret_ok;
        logic [1:0] por_sync;
        logic [1:0][3:0] bus_sync;
        logic [NUMBERS-1:0][CHARS-1:0][3:0] mem;
        logic [NUMBERS-1:0][AW-1:0] lens;
        rns_pkg::rns_pins_type pins;
    } rns_state_all_type;

    // Registered state and its next value
    rns_state_all_type st, next_st;
    rns_pkg::rns_char_type fifo_out;
    logic fifo_valid, fifo_ready, fifo_push, fifo_pop, fifo_flush;
    logic [3:0] bus_raw, bus_now, push_code;
    logic key_fall, cs, cle, sto, ret, key_lvl;
    logic por_clear;

    // Map a key code to an address index, 0xF when invalid
    function automatic logic [3:0] code_to_addr(input logic [3:0] c);
        if (c == CODE_ZERO) begin
            return 4'h0;
        end else if (c >= 4'h1 && c <= 4'h9) begin
            return c;
        end
        return 4'hF;
    endfunction

    // Storable characters: digits and access pause
    function automatic logic code_ok(input logic [3:0] c);
        return (code_to_addr(c) != 4'hF) || (c == CODE_PAUSE);
    endfunction

    assign bus_raw = {bus_line_four_in, bus_line_three_in, bus_line_two_in,
        bus_line_one_in};
    assign cs = st.filt[0];
    assign cle = st.filt[1];
    assign sto = st.filt[2];
    assign ret = st.filt[3];
    assign key_lvl = st.filt[4];
    assign key_fall = st.filt_d[4] && !st.filt[4];
    // Bus is active low; invert to get the code
    assign bus_now = ~st.bus_sync[1];
    // Power-on reset level after its own two-flop synchroniser
    assign por_clear = !st.por_sync[1];

    // Replay buffer between the store and the bus strobe
    rns_fifo #(
        .WIDTH(4),
        .DEPTH(`RNS_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .flush_in(fifo_flush),
        .in_valid_in(fifo_push),
        .in_data_in(push_code),
        .in_ready_out(fifo_ready),
        .out_valid_out(fifo_valid),
        .out_data_out(fifo_out),
        .out_ready_in(fifo_pop)
    );

    // Main sequencing
    always_comb begin
        next_st = st;
        fifo_push = 1'b0;
        fifo_pop = 1'b0;
        fifo_flush = 1'b0;
        push_code = st.mem[st.addr][st.idx];
        // Two-stage synchronisers on every pin group
        next_st.sync[0] = {common_key_n_in, retrieve_in, store_in,
            ctrl_enable_in, chip_select_in};
        next_st.sync[1] = st.sync[0];
        next_st.bus_sync[0] = bus_raw;
        next_st.bus_sync[1] = st.bus_sync[0];
        next_st.por_sync = {st.por_sync[0], por_n_in};
        next_st.filt_d = st.filt;
        // Debounce each control input on both edges
        for (int i = 0; i < 5; i++) begin
            if (st.sync[1][i] == st.filt[i]) begin
                next_st.cnt[i] = '0;
            end else if (st.cnt[i] >= CW'(DEBOUNCE_CYC - 1)) begin
                next_st.filt[i] = st.sync[1][i];
                next_st.cnt[i] = '0;
            end else begin
                next_st.cnt[i] = st.cnt[i] + 1'b1;
            end
        end
        // Retrieve must stay high for the minimum time
        if (!ret) begin
            next_st.ret_high = '0;
            next_st.ret_ok = 1'b0;
        end else if (st.ret_high >= CW'(RETRIEVE_CYC - 1)) begin
            next_st.ret_ok = 1'b1;
        end else begin
            next_st.ret_high = st.ret_high + 1'b1;
        end
        next_st.pins.bus_oe = 4'h0;
        next_st.pins.bus_out = 4'hF;
        // Idle: debounced common key passes through when not controlling
        next_st.pins.common_n = key_lvl;
        next_st.pins.dig_kbd_dis_n = 1'b1;
        next_st.pins.addr_kbd_dis_n = 1'b1;
        case (st.fsm)
            rns_pkg::RNS_IDLE: begin
                next_st.idx = '0;
                if (cle && cs) begin
                    next_st.pins.common_n = 1'b1;
                    if (sto) begin
                        next_st.is_store = 1'b1;
                        next_st.fsm = rns_pkg::RNS_ADDR;
                    end else if (st.ret_ok) begin
                        next_st.is_store = 1'b0;
                        next_st.fsm = rns_pkg::RNS_ADDR;
                    end
                end else if (cle && !cs) begin
                    next_st.pins.common_n = 1'b1;
                end
            end
            rns_pkg::RNS_ADDR: begin
                next_st.pins.common_n = 1'b1;
                if (key_fall && code_to_addr(bus_now) < 4'(NUMBERS)) begin
                    next_st.addr = code_to_addr(bus_now);
                    next_st.fsm = rns_pkg::RNS_CLEAR;
                    next_st.timer = '0;
                end
            end
            rns_pkg::RNS_CLEAR: begin
                next_st.pins.common_n = 1'b1;
                next_st.pins.addr_kbd_dis_n = 1'b0;
                if (st.is_store) begin
                    next_st.lens[st.addr] = '0;
                    next_st.fsm = rns_pkg::RNS_DIGITS;
                end else begin
                    next_st.len = st.lens[st.addr];
                    next_st.pins.dig_kbd_dis_n = 1'b0;
                    next_st.fsm = rns_pkg::RNS_GAP;
                end
            end
            rns_pkg::RNS_DIGITS: begin
                next_st.pins.common_n = 1'b1;
                next_st.pins.addr_kbd_dis_n = 1'b0;
                if (key_fall && cs && code_ok(bus_now)
                    && st.idx < AW'(CHARS)) begin
                    next_st.mem[st.addr][st.idx] = bus_now;
                    next_st.idx = st.idx + 1'b1;
                    next_st.lens[st.addr] = st.idx + 1'b1;
                end
            end
            rns_pkg::RNS_GAP: begin
                // Quiet half of the cadence; queue next character
                next_st.pins.common_n = 1'b1;
                next_st.pins.dig_kbd_dis_n = 1'b0;
                next_st.pins.addr_kbd_dis_n = 1'b0;
                if (st.idx < st.len && fifo_ready) begin
                    fifo_push = 1'b1;
                    next_st.idx = st.idx + 1'b1;
                end
                if (st.timer >= CW'(STROBE_CYC - 1)) begin
                    if (fifo_valid) begin
                        next_st.timer = '0;
                        next_st.fsm = rns_pkg::RNS_SEND;
                        // Strobe starts with the state, a full period
                        next_st.pins.bus_oe = 4'hF;
                        next_st.pins.bus_out = ~fifo_out.code;
                        next_st.pins.common_n = 1'b0;
                    end else if (st.idx >= st.len) begin
                        next_st.fsm = rns_pkg::RNS_DONE;
                    end
                end else begin
                    next_st.timer = st.timer + 1'b1;
                end
            end
            rns_pkg::RNS_SEND: begin
                // Code stable on the bus for the whole strobe
                next_st.pins.dig_kbd_dis_n = 1'b0;
                next_st.pins.addr_kbd_dis_n = 1'b0;
                next_st.pins.bus_oe = 4'hF;
                next_st.pins.bus_out = ~fifo_out.code;
                next_st.pins.common_n = 1'b0;
                if (st.timer >= CW'(STROBE_CYC - 1)) begin
                    fifo_pop = 1'b1;
                    next_st.timer = '0;
                    next_st.pins.common_n = 1'b1;
                    next_st.pins.bus_oe = 4'h0;
                    next_st.pins.bus_out = 4'hF;
                    next_st.fsm = rns_pkg::RNS_GAP;
                end else begin
                    next_st.timer = st.timer + 1'b1;
                end
            end
            rns_pkg::RNS_DONE: begin
                // Replay over: common key gated through again
                next_st.is_store = 1'b0;
                if (!cle) begin
                    next_st.fsm = rns_pkg::RNS_IDLE;
                end
            end
            default: begin
                next_st.fsm = rns_pkg::RNS_IDLE;
            end
        endcase
        // Store ends when store input drops
        if (st.is_store && st.fsm != rns_pkg::RNS_IDLE && !sto) begin
            next_st.fsm = rns_pkg::RNS_IDLE;
        end
        // Chip select dropped mid-operation abandons it
        if (!cs && st.fsm != rns_pkg::RNS_IDLE) begin
            next_st.fsm = rns_pkg::RNS_IDLE;
            next_st.is_store = 1'b0;
            next_st.pins.dig_kbd_dis_n = 1'b1;
            next_st.pins.addr_kbd_dis_n = 1'b1;
            next_st.pins.bus_oe = 4'h0;
            next_st.pins.bus_out = 4'hF;
            next_st.pins.common_n = 1'b1;
            fifo_flush = 1'b1;
        end
        // Enable low resets the control logic
        if (!cle) begin
            next_st.fsm = rns_pkg::RNS_IDLE;
            next_st.is_store = 1'b0;
            next_st.pins.dig_kbd_dis_n = 1'b1;
            next_st.pins.addr_kbd_dis_n = 1'b1;
            next_st.pins.bus_oe = 4'h0;
            next_st.pins.bus_out = 4'hF;
            next_st.pins.common_n = key_lvl;
            fifo_flush = 1'b1;
        end
        // Power-on reset clears all stored state
        if (por_clear) begin
            next_st = '0;
            next_st.por_sync = {st.por_sync[0], por_n_in};
            next_st.filt = 5'h10;
            next_st.filt_d = 5'h10;
            next_st.pins.common_n = 1'b1;
            next_st.pins.bus_out = 4'hF;
            next_st.pins.dig_kbd_dis_n = 1'b1;
            next_st.pins.addr_kbd_dis_n = 1'b1;
            fifo_flush = 1'b1;
        end
    end

    // State register; reset gives idle pins
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            st <= '0;
            st.filt <= 5'h10;
            st.filt_d <= 5'h10;
            st.pins.common_n <= 1'b1;
            st.pins.bus_out <= 4'hF;
            st.pins.dig_kbd_dis_n <= 1'b1;
            st.pins.addr_kbd_dis_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Registered pin drivers
    assign bus_line_one_out = st.pins.bus_out[0];
    assign bus_line_two_out = st.pins.bus_out[1];
    assign bus_line_three_out = st.pins.bus_out[2];
    assign bus_line_four_out = st.pins.bus_out[3];
    assign bus_oe_out = st.pins.bus_oe;
    assign dig_kbd_dis_n_out = st.pins.dig_kbd_dis_n;
    assign addr_kbd_dis_n_out = st.pins.addr_kbd_dis_n;
    assign common_key_n_out = st.pins.common_n;
endmodule // rns_store
`default_nettype wire

//--- hdl/rns_consts.svh
// Constants for the repertory number store
`ifndef RNS_CONSTS_SVH
`define RNS_CONSTS_SVH
`define RNS_CLK_HZ 10000000
`define RNS_NUMBERS 10
`define RNS_CHARS 22
`define RNS_RETRIEVE_MIN_MS 10
`define RNS_STROBE_MS 60
`define RNS_DEBOUNCE_US 2000
`define RNS_RETRIEVE_CYC ((`RNS_RETRIEVE_MIN_MS * `RNS_CLK_HZ) / 1000)
`define RNS_STROBE_CYC ((`RNS_STROBE_MS * `RNS_CLK_HZ) / 1000)
`define RNS_DEBOUNCE_CYC ((`RNS_DEBOUNCE_US * (`RNS_CLK_HZ / 1000)) / 1000)
`define RNS_FIFO_DEPTH 16
`define RNS_CODE_PAUSE 4'hB
`define RNS_CODE_ZERO 4'hA
`define RNS_CODE_EMPTY 4'hF
`endif

//--- hdl/rns_pkg.sv
// Types for the repertory number store
package rns_pkg;
    typedef enum logic [2:0] {
        RNS_IDLE = 3'h0,
        RNS_ADDR = 3'h1,
        RNS_CLEAR = 3'h3,
        RNS_DIGITS = 3'h2,
        RNS_GAP = 3'h6,
        RNS_SEND = 3'h7,
        RNS_DONE = 3'h5
    } rns_state_type;

    typedef struct packed {
        logic [3:0] code;
    } rns_char_type;

    typedef struct packed {
        logic dig_kbd_dis_n;
        logic addr_kbd_dis_n;
        logic common_n;
        logic [3:0] bus_out;
        logic [3:0] bus_oe;
    } rns_pins_type;
endpackage

//--- hdl/rns_fifo.sv
// Small flip-flop FIFO in front of the replay path
`timescale 1ns/1ns
`default_nettype none
module rns_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic flush_in,
    // Fill side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // Drain side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] count;
    } rns_fifo_state_type;
    rns_fifo_state_type st, next_st;
    logic push, pop;

    // Handshake terms
    assign in_ready_out = (st.count != DEPTH[AW:0]);
    assign out_valid_out = (st.count != '0);
    assign out_data_out = st.mem[st.rd];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // Pointer and storage update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data_in;
            next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
        end
        next_st.count = st.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        if (flush_in) begin
            next_st.rd = '0;
            next_st.wr = '0;
            next_st.count = '0;
        end
    end

    // State register
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule // rns_fifo
`default_nettype wire

//--- sim/rns_store_properties.sv
// Pin-level property checker for the repertory number store
`timescale 1ns/1ns
`default_nettype none
module rns_store_properties #(
    parameter int STROBE_CYC = 20
) (
    // Clock and resets
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic por_n_in,
    // Control pins
    input wire logic chip_select_in,
    input wire logic ctrl_enable_in,
    // Bus and strobe outputs
    input wire logic bus_line_one_out,
    input wire logic bus_line_two_out,
    input wire logic bus_line_three_out,
    input wire logic bus_line_four_out,
    input wire logic [3:0] bus_oe_out,
    input wire logic dig_kbd_dis_n_out,
    input wire logic addr_kbd_dis_n_out,
    input wire logic common_key_n_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    logic [3:0] lines;
    int strobe_cnt;
    assign lines = {bus_line_four_out, bus_line_three_out,
                    bus_line_two_out, bus_line_one_out};
    // Length of the current low stretch of the dialler strobe
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            strobe_cnt <= 0;
        end else if (common_key_n_out) begin
            strobe_cnt <= 0;
        end else begin
            strobe_cnt <= strobe_cnt + 1;
        end
    end
    sequence replay_strobe_s;
        !common_key_n_out && !dig_kbd_dis_n_out;
    endsequence
    sequence enable_held_s;
        ctrl_enable_in [*8] ##0 dig_kbd_dis_n_out;
    endsequence
    AST_RESET_IDLE: assert property ($fell(rst_in) |-> bus_oe_out == 4'h0
        && lines == 4'hF && dig_kbd_dis_n_out && addr_kbd_dis_n_out)
        else $error("outputs not idle after reset");
    AST_POR_CLEAR: assert property (!por_n_in [*3] |=> bus_oe_out == 4'h0
        && dig_kbd_dis_n_out && addr_kbd_dis_n_out)
        else $error("power-on clear left outputs active");
    AST_OE_STROBE: assert property (bus_oe_out != 4'h0 |->
        bus_oe_out == 4'hF && !common_key_n_out && !dig_kbd_dis_n_out)
        else $error("bus driven outside a strobe");
    AST_REST_HIGH: assert property (bus_oe_out == 4'h0 |-> lines == 4'hF)
        else $error("bus output not at rest level");
    AST_CODE_STABLE: assert property (replay_strobe_s ##1 replay_strobe_s
        |-> $stable(lines) && $stable(bus_oe_out))
        else $error("code changed under the strobe");
    AST_STROBE_LEN: assert property ($rose(common_key_n_out)
        && !dig_kbd_dis_n_out |-> strobe_cnt == STROBE_CYC)
        else $error("strobe length wrong");
    AST_FIRST_GAP: assert property ($fell(dig_kbd_dis_n_out) |->
        (common_key_n_out && bus_oe_out == 4'h0) [*8])
        else $error("strobe too soon after address");
    AST_DIG_ADDR: assert property (!dig_kbd_dis_n_out |->
        !addr_kbd_dis_n_out) else $error("address keyboard not disabled");
    AST_CS_INHIBIT: assert property (!chip_select_in [*8] |->
        bus_oe_out == 4'h0 && dig_kbd_dis_n_out)
        else $error("deselected store active");
    AST_ENABLE_RESET: assert property (!ctrl_enable_in [*8] |=>
        dig_kbd_dis_n_out && addr_kbd_dis_n_out)
        else $error("disables held without enable");
    AST_HOLD_COMMON: assert property (enable_held_s |-> common_key_n_out)
        else $error("strobe leaked while enabled");
endmodule // rns_store_properties
bind rns_store rns_store_properties #(.STROBE_CYC(STROBE_CYC)) u_props (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .por_n_in(por_n_in),
    .chip_select_in(chip_select_in), .ctrl_enable_in(ctrl_enable_in),
    .bus_line_one_out(bus_line_one_out), .bus_line_two_out(bus_line_two_out),
    .bus_line_three_out(bus_line_three_out),
    .bus_line_four_out(bus_line_four_out), .bus_oe_out(bus_oe_out),
    .dig_kbd_dis_n_out(dig_kbd_dis_n_out),
    .addr_kbd_dis_n_out(addr_kbd_dis_n_out),
    .common_key_n_out(common_key_n_out));
`default_nettype wire

//--- sim/rns_keypad_model.sv
// Keyboard and dialler model on the shared four-line bus
`timescale 1ns/1ns
`default_nettype none
module rns_keypad_model #(
    parameter int DEBOUNCE_CYC = 4
) (
    // Clock
    input wire logic clk_sys_in,
    // Store side of the bus
    input wire logic [3:0] bus_oe_in,
    input wire logic [3:0] store_lines_in,
    input wire logic dial_common_n_in,
    // Resolved bus and keyboard common
    output logic [3:0] lines_out,
    output logic key_common_n_out
);
    logic [3:0] key_code = 4'h0;
    logic key_drive = 1'b0;
    logic prev_common = 1'b1;
    logic [3:0] got[$];
    // Pull-ups, store drive and keyboard drive on one wire each
    assign lines_out = (~bus_oe_in | store_lines_in)
        & (key_drive ? ~key_code : 4'hF);
    initial key_common_n_out = 1'b1;
    // One key closure: code on the bus, then common pulled low
    task automatic press(input logic [3:0] code);
        @(posedge clk_sys_in);
        key_code <= code;
        key_drive <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        key_common_n_out <= 1'b0;
        repeat (DEBOUNCE_CYC + 6) @(posedge clk_sys_in);
        key_common_n_out <= 1'b1;
        repeat (DEBOUNCE_CYC + 4) @(posedge clk_sys_in);
        key_drive <= 1'b0;
    endtask
    // Dialler takes the code where its common input falls
    always @(posedge clk_sys_in) begin
        prev_common <= dial_common_n_in;
        if (prev_common && !dial_common_n_in) begin
            got.push_back(~lines_out);
        end
    end
endmodule // rns_keypad_model
`default_nettype wire

//--- sim/repertory_number_store_bench.sv
// Self-checking bench for the repertory number store
`timescale 1ns/1ns
`default_nettype none
module repertory_number_store_bench;
    localparam int DB = 4;
    localparam int SC = 20;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic por_n_in = 1'b1;
    logic chip_select_in = 1'b0;
    logic retrieve_in = 1'b0;
    logic ctrl_enable_in = 1'b0;
    logic store_in = 1'b0;
    wire logic key_n;
    wire logic [3:0] lines;
    wire logic [3:0] store_lines;
    wire logic [3:0] bus_oe_out;
    wire logic dig_kbd_dis_n_out, addr_kbd_dis_n_out, common_key_n_out;
    int bad_count = 0;
    int checked = 0;
    always #50 clk_sys_in = ~clk_sys_in;
    rns_store #(.RETRIEVE_CYC(8), .STROBE_CYC(SC), .DEBOUNCE_CYC(DB)) uut (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .por_n_in(por_n_in),
        .chip_select_in(chip_select_in), .retrieve_in(retrieve_in),
        .ctrl_enable_in(ctrl_enable_in), .store_in(store_in),
        .common_key_n_in(key_n), .bus_line_one_in(lines[0]),
        .bus_line_two_in(lines[1]), .bus_line_three_in(lines[2]),
        .bus_line_four_in(lines[3]), .bus_line_one_out(store_lines[0]),
        .bus_line_two_out(store_lines[1]),
        .bus_line_three_out(store_lines[2]),
        .bus_line_four_out(store_lines[3]), .bus_oe_out(bus_oe_out),
        .dig_kbd_dis_n_out(dig_kbd_dis_n_out),
        .addr_kbd_dis_n_out(addr_kbd_dis_n_out),
        .common_key_n_out(common_key_n_out));
    rns_keypad_model #(.DEBOUNCE_CYC(DB)) u_kbd (
        .clk_sys_in(clk_sys_in), .bus_oe_in(bus_oe_out),
        .store_lines_in(store_lines), .dial_common_n_in(common_key_n_out),
        .lines_out(lines), .key_common_n_out(key_n));
    task automatic summarize();
        $display("Counts: %0d checked, %0d bad", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask
    task automatic wait_dig(input logic v, input int lim);
        for (int i = 0; i < lim && dig_kbd_dis_n_out !== v; i++) tick(1);
        if (dig_kbd_dis_n_out !== v) begin
            bad_count++;
            $display("unexpected at %0t: digit disable wait ran out", $time);
            summarize();
        end
    endtask
    // Character stored at position i: digits, zero and pause in turn
    function automatic logic [3:0] exp_code(input int i);
        return 4'(i % 11 + 1);
    endfunction
    task automatic t_reset();
        check(bus_oe_out === 4'h0 && store_lines === 4'hF, "bus busy");
        check(dig_kbd_dis_n_out === 1'b1 && addr_kbd_dis_n_out === 1'b1
            && common_key_n_out === 1'b1, "pins not idle");
        $display("test reset done");
    endtask
    task automatic t_passthru();
        u_kbd.got.delete();
        u_kbd.press(4'h5);
        tick(DB + 4);
        check(u_kbd.got.size() == 1 && u_kbd.got[0] === 4'h5, "no pass");
        $display("test pass-through done");
    endtask
    task automatic t_store(input logic [3:0] addr, input int n);
        @(posedge clk_sys_in);
        chip_select_in <= 1'b1;
        ctrl_enable_in <= 1'b1;
        store_in <= 1'b1;
        tick(DB + 6);
        u_kbd.got.delete();
        u_kbd.press(addr);
        check(addr_kbd_dis_n_out === 1'b0
            && dig_kbd_dis_n_out === 1'b1, "address keyboard live");
        for (int i = 0; i < n; i++) begin
            if (i == 5) u_kbd.press(4'hE);
            u_kbd.press(exp_code(i));
        end
        check(u_kbd.got.size() == 0, "stored key reached dialler");
        @(posedge clk_sys_in);
        store_in <= 1'b0;
        ctrl_enable_in <= 1'b0;
        tick(DB + 8);
        check(addr_kbd_dis_n_out === 1'b1, "address keyboard held");
        $display("test store %0d done", n);
    endtask
    task automatic t_retrieve(input logic [3:0] addr, input int n);
        @(posedge clk_sys_in);
        chip_select_in <= 1'b1;
        ctrl_enable_in <= 1'b1;
        retrieve_in <= 1'b1;
        tick(DB + 14);
        u_kbd.got.delete();
        u_kbd.press(addr);
        retrieve_in <= 1'b0;
        if (n > 0) wait_dig(1'b0, 50);
        wait_dig(1'b1, 60 * SC);
        check(u_kbd.got.size() == n, "wrong character count");
        for (int i = 0; i < n && i < u_kbd.got.size(); i++) begin
            check(u_kbd.got[i] === exp_code(i), "wrong code");
        end
        check(addr_kbd_dis_n_out === 1'b1 && common_key_n_out === 1'b1,
            "pins not released");
        @(posedge clk_sys_in);
        ctrl_enable_in <= 1'b0;
        tick(DB + 8);
        $display("test retrieve %0d done", n);
    endtask
    task automatic t_refuse(input logic cs, input int rlen);
        @(posedge clk_sys_in);
        chip_select_in <= cs;
        ctrl_enable_in <= 1'b1;
        retrieve_in <= 1'b1;
        u_kbd.got.delete();
        fork
            begin
                tick(rlen);
                retrieve_in <= 1'b0;
            end
            begin
                tick(DB + 14);
                u_kbd.press(4'h1);
            end
        join
        tick(2 * SC);
        check(dig_kbd_dis_n_out === 1'b1 && u_kbd.got.size() == 0,
            "retrieve not refused");
        ctrl_enable_in <= 1'b0;
        tick(DB + 8);
        $display("test refusal done");
    endtask
    task automatic t_por();
        @(posedge clk_sys_in);
        por_n_in <= 1'b0;
        tick(3);
        por_n_in <= 1'b1;
        tick(DB + 4);
        $display("test power-on clear done");
    endtask
    initial begin
        tick(6);
        rst_in <= 1'b0;
        tick(DB + 4);
        t_reset();
        t_passthru();
        t_store(4'h1, 3);
        t_store(4'hA, 23);
        t_retrieve(4'hA, 22);
        t_retrieve(4'h1, 3);
        t_refuse(1'b0, 60);
        t_refuse(1'b1, DB + 2);
        t_store(4'hA, 0);
        t_retrieve(4'hA, 0);
        t_por();
        t_retrieve(4'h1, 0);
        summarize();
    end
endmodule // repertory_number_store_bench
`default_nettype wire
